// File: inc/uip_pkg.sv
// Package of register map, fields, codes and reset values for the interrupt prioritizer
package uip_pkg;

  // Register byte offsets on the bus
  localparam logic [3:0] OFS_DATA   = 4'h0;
  localparam logic [3:0] OFS_ENABLE = 4'h4;
  localparam logic [3:0] OFS_IDENT  = 4'h8;
  localparam logic [3:0] OFS_LSTAT  = 4'hC;

  // Reset values
  localparam logic [7:0] IER_RST    = 8'h00;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  // Enable register bit positions
  localparam int IE_RXDATA = 0;
  localparam int IE_THR    = 1;
  localparam int IE_LINE   = 2;
  localparam int IE_MODEM  = 3;
  localparam int IE_SLEEP  = 4;
  localparam int IE_XOFF   = 5;
  localparam int IE_RTS    = 6;
  localparam int IE_CTS    = 7;

  // Identification codes in bits 5..0; bit 0 high means nothing pending
  localparam logic [5:0] IID_NONE = 6'h01;
  localparam logic [5:0] IID_LINE = 6'h06;
  localparam logic [5:0] IID_TOUT = 6'h0C;
  localparam logic [5:0] IID_RXD  = 6'h04;
  localparam logic [5:0] IID_THR  = 6'h02;
  localparam logic [5:0] IID_XOFF = 6'h10;
  localparam logic [5:0] IID_FLOW = 6'h20;

  // Line status bit positions
  localparam int LS_DAVAIL = 0;
  localparam int LS_OVR    = 1;
  localparam int LS_ERRTOP = 2;
  localparam int LS_THRE   = 5;
  localparam int LS_ERRSUM = 7;

  // Sticky flag indices
  localparam int SB_OVR  = 0;
  localparam int SB_TOUT = 1;
  localparam int SB_THR  = 2;
  localparam int SB_XOFF = 3;
  localparam int SB_RTS  = 4;
  localparam int SB_CTS  = 5;
  localparam int SB_N    = 6;

  // Enabled-pending vector indices, highest priority first
  localparam int PR_LINE = 0;
  localparam int PR_TOUT = 1;
  localparam int PR_RXD  = 2;
  localparam int PR_THR  = 3;
  localparam int PR_XOFF = 4;
  localparam int PR_FLOW = 5;
  localparam int PR_N    = 6;

  // Highest-priority pending type to identification code
  function automatic logic [5:0] ident_code(input logic [PR_N-1:0] p);
    logic [5:0] c;
    c = IID_NONE;
    if (p[PR_LINE]) begin
      c = IID_LINE;
    end else if (p[PR_TOUT]) begin
      c = IID_TOUT;
    end else if (p[PR_RXD]) begin
      c = IID_RXD;
    end else if (p[PR_THR]) begin
      c = IID_THR;
    end else if (p[PR_XOFF]) begin
      c = IID_XOFF;
    end else if (p[PR_FLOW]) begin
      c = IID_FLOW;
    end
    return c;
  endfunction

endpackage

// File: inc/uip_sticky_if.sv
// Interface carrying set, clear and state of the sticky event flags
`timescale 1ns/100ps
interface uip_sticky_if #(
  parameter int N = 6
);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] q;
  modport ctl  (output set, output clr, input q);
  modport bank (input set, input clr, output q);
endinterface

// File: rtl/uip_sticky.sv
// Bank of sticky event flags where a set beats a simultaneous clear
`timescale 1ns/100ps
module uip_sticky #(
  parameter int N = 6
) (
  input  wire logic clk_i,     // System clock
  input  wire logic rst_i,     // Synchronous reset, active high
  uip_sticky_if.bank sb        // Flag set, clear and state
);

  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;

  // Set wins so an event landing on its clear cycle is kept
  always_comb begin
    flag_next = sb.set | (flag_reg & ~sb.clr);
  end

  // Flag register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign sb.q = flag_reg;

endmodule

// File: rtl/uip_top.sv
// Interrupt prioritizer for one UART channel with a Wishbone register slave
`timescale 1ns/100ps
// Operation
// R1 - Six interrupt types at fixed priority; only the highest pending one is reported.
// R2 - Each type has its own enable bit; the pin follows enabled sources only. Time-out and receive data share enable bit 0 here.
// R3 - Enable bits 0-3 and 5-7 all clear silences the interrupt pin.
// R4 - Ident register flags a pending interrupt and codes its type in bits 5..0.
// R5 - Level 1 on receive errors; error causes clear when read out, overrun on status read.
// R6 - Level 2 time-out on stale receive data, cleared by a receive holding read.
// R7 - Level 2 receive data on data ready or trigger level, cleared by holding read.
// R8 - Level 3 on empty transmit holding, cleared by ident read or holding write. The code raises it only while queues are disabled.
// R9 - Error summary flag stays set while any erroneous character remains queued.
// R10 - Level 5 flow-stop from stop character clears on matching resume character.
// R11 - Level 5 flow-stop from special character clears on a line status read.
// R12 - Level 6 on RTS or CTS going inactive high, cleared by ident read.
// R13 - Interrupt pin high while an enabled source pends, low once all cleared.
// R14 - Host reads ident then does that type's clearing action to see lower ones.
module uip_top
  import uip_pkg::*;
(
  input  wire logic        clk_i,         // System clock, 40 MHz
  input  wire logic        rst_i,         // Synchronous reset, active high
  input  wire logic        wb_cyc_i,      // Bus cycle
  input  wire logic        wb_stb_i,      // Bus strobe
  input  wire logic        wb_we_i,       // Write enable
  input  wire logic [3:0]  wb_adr_i,      // Byte address
  input  wire logic [3:0]  wb_sel_i,      // Byte lane selects
  input  wire logic [31:0] wb_dat_i,      // Write data
  output logic      [31:0] wb_dat_o,      // Read data
  output logic             wb_ack_o,      // Acknowledge
  input  wire logic [7:0]  rx_data_i,     // Character at receive queue head
  input  wire logic        rx_avail_i,    // Receive data available
  input  wire logic        rx_trig_i,     // Receive queue above trigger level
  input  wire logic        fifo_en_i,     // Queues enabled
  input  wire logic        rx_err_any_i,  // Error anywhere in receive queue
  input  wire logic [2:0]  rx_err_top_i,  // Break, framing, parity of head character
  input  wire logic        overrun_i,     // Overrun event pulse
  input  wire logic        rx_stale_i,    // Receive time-out event pulse
  input  wire logic        tx_empty_i,    // Transmit holding empty
  input  wire logic        xoff_det_i,    // Flow-stop character seen, pulse
  input  wire logic        xon_det_i,     // Flow-resume character seen, pulse
  input  wire logic        special_det_i, // Special character seen, pulse
  input  wire logic        rts_n_i,       // RTS pin level, active low
  input  wire logic        cts_n_i,       // CTS pin level, active low
  output logic             irq_o,         // Interrupt output, active high
  output logic             rx_read_o,     // Pulse: receive holding read
  output logic             tx_write_o,    // Pulse: transmit holding write
  output logic      [7:0]  tx_data_o      // Transmit character
);

  // Address decode shared by reads and writes
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    return (a[3:2] == ofs[3:2]);
  endfunction

  uip_sticky_if #(.N(SB_N)) sb ();

  uip_sticky #(
    .N (SB_N)
  ) u_sticky (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sb    (sb.bank)
  );

  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [7:0]  ier_reg;
  logic [7:0]  ier_next;
  logic        irq_reg;
  logic        irq_next;
  logic        rxrd_reg;
  logic        rxrd_next;
  logic        txwr_reg;
  logic        txwr_next;
  logic [7:0]  txd_reg;
  logic [7:0]  txd_next;
  logic        xspec_reg;
  logic        xspec_next;
  logic        txe_prev_reg;
  logic        rts_prev_reg;
  logic        cts_prev_reg;

  logic            acc;
  logic            rd_data;
  logic            rd_ident;
  logic            rd_lstat;
  logic            wr_data;
  logic [PR_N-1:0] pend;
  logic [5:0]      code;
  logic [7:0]      lstat;

  // A request is served once, in the cycle before the ack flop rises
  assign acc      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign rd_data  = acc & ~wb_we_i & hit(wb_adr_i, OFS_DATA);
  assign rd_ident = acc & ~wb_we_i & hit(wb_adr_i, OFS_IDENT);
  assign rd_lstat = acc & ~wb_we_i & hit(wb_adr_i, OFS_LSTAT);
  assign wr_data  = acc & wb_we_i & wb_sel_i[0] & hit(wb_adr_i, OFS_DATA);

  // Enabled pending sources; the error summary level drives level 1
  always_comb begin
    pend          = '0;
    pend[PR_LINE] = ier_reg[IE_LINE] & (rx_err_any_i | sb.q[SB_OVR]); // R5 R9 R2
    pend[PR_TOUT] = ier_reg[IE_RXDATA] & sb.q[SB_TOUT];             // R6
    pend[PR_RXD]  = ier_reg[IE_RXDATA] & (fifo_en_i ? rx_trig_i : rx_avail_i); // R7
    pend[PR_THR]  = ier_reg[IE_THR] & sb.q[SB_THR];                 // R8
    pend[PR_XOFF] = ier_reg[IE_XOFF] & sb.q[SB_XOFF];               // R10 R11
    pend[PR_FLOW] = (ier_reg[IE_RTS] & sb.q[SB_RTS])
                  | (ier_reg[IE_CTS] & sb.q[SB_CTS]);               // R12
  end

  // Only the winner is coded; lower types wait for its clear
  assign code = ident_code(pend); // R1 R4 R14

  // Line status as seen by software
  always_comb begin
    lstat                       = BYTE_ZERO;
    lstat[LS_DAVAIL]            = rx_avail_i;
    lstat[LS_OVR]               = sb.q[SB_OVR];
    lstat[LS_ERRTOP +: 3]       = rx_err_top_i;
    lstat[LS_THRE]              = tx_empty_i;
    lstat[LS_ERRSUM]            = rx_err_any_i; // R9
  end

  // Event sets: a new event always beats its clear in the flag bank
  always_comb begin
    sb.set          = '0;
    sb.set[SB_OVR]  = overrun_i;                          // R5
    sb.set[SB_TOUT] = rx_stale_i;                         // R6
    sb.set[SB_THR]  = ~fifo_en_i & tx_empty_i & ~txe_prev_reg; // R8
    sb.set[SB_XOFF] = xoff_det_i | special_det_i;
    sb.set[SB_RTS]  = rts_n_i & ~rts_prev_reg;            // R12
    sb.set[SB_CTS]  = cts_n_i & ~cts_prev_reg;            // R12
  end

  // Clearing actions; ident read clears only the type it reported
  always_comb begin
    sb.clr          = '0;
    sb.clr[SB_OVR]  = rd_lstat;                                  // R5
    sb.clr[SB_TOUT] = rd_data;                                   // R6
    sb.clr[SB_THR]  = wr_data | (rd_ident & (code == IID_THR));  // R8
    sb.clr[SB_XOFF] = xspec_reg ? rd_lstat : xon_det_i;          // R10 R11
    sb.clr[SB_RTS]  = rd_ident & (code == IID_FLOW);             // R12
    sb.clr[SB_CTS]  = rd_ident & (code == IID_FLOW);             // R12
  end

  // Cause of the flow-stop flag; the latest detection decides, and a stop character wins over a special character in the same cycle
  always_comb begin
    xspec_next = xspec_reg;
    if (xoff_det_i) begin
      xspec_next = 1'b0;
    end else if (special_det_i) begin
      xspec_next = 1'b1;
    end
  end

  // Bus slave next state; reads outside data, enable and ident give line status, other writes are dropped
  always_comb begin
    ack_next  = acc;
    dat_next  = '0;
    ier_next  = ier_reg;
    rxrd_next = rd_data;
    txwr_next = wr_data;
    txd_next  = txd_reg;
    if (acc && wb_we_i && wb_sel_i[0]) begin
      if (hit(wb_adr_i, OFS_ENABLE)) begin
        ier_next = wb_dat_i[7:0]; // R2 R3
      end
      if (hit(wb_adr_i, OFS_DATA)) begin
        txd_next = wb_dat_i[7:0];
      end
    end
    if (acc && !wb_we_i) begin
      if (hit(wb_adr_i, OFS_DATA)) begin
        dat_next[7:0] = rx_data_i;
      end else if (hit(wb_adr_i, OFS_ENABLE)) begin
        dat_next[7:0] = ier_reg;
      end else if (hit(wb_adr_i, OFS_IDENT)) begin
        dat_next[5:0] = code; // R4
      end else begin
        dat_next[7:0] = lstat;
      end
    end
  end

  // Interrupt pin; a cleared enable set can never pass a source
  always_comb begin
    irq_next = |pend; // R13 R2 R3
  end

  // Bus and pin registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      dat_reg   <= '0;
      ier_reg   <= IER_RST;
      irq_reg   <= 1'b0;
      rxrd_reg  <= 1'b0;
      txwr_reg  <= 1'b0;
      txd_reg   <= BYTE_ZERO;
      xspec_reg <= 1'b0;
    end else begin
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      ier_reg   <= ier_next;
      irq_reg   <= irq_next;
      rxrd_reg  <= rxrd_next;
      txwr_reg  <= txwr_next;
      txd_reg   <= txd_next;
      xspec_reg <= xspec_next;
    end
  end

  // Edge history; modem pins reset inactive so reset release is not an edge for them, but transmit empty history resets low so its release is one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txe_prev_reg <= 1'b0;
      rts_prev_reg <= 1'b1;
      cts_prev_reg <= 1'b1;
    end else begin
      txe_prev_reg <= tx_empty_i;
      rts_prev_reg <= rts_n_i;
      cts_prev_reg <= cts_n_i;
    end
  end

  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = dat_reg;
  assign irq_o      = irq_reg;
  assign rx_read_o  = rxrd_reg;
  assign tx_write_o = txwr_reg;
  assign tx_data_o  = txd_reg;

  // Pin follows an enabled pending source within one cycle
  chk_irq_follows: assert property ( // R13
    @(posedge clk_i) disable iff (rst_i)
    (|pend) [*2] |-> irq_o)
    else $error("irq not raised for pending source");

  // Pin falls once nothing enabled pends
  chk_irq_drops: assert property ( // R13
    @(posedge clk_i) disable iff (rst_i)
    !(|pend) [*2] |-> !irq_o)
    else $error("irq stuck after sources cleared");

  // No enables means a silent pin
  chk_all_off: assert property ( // R3
    @(posedge clk_i) disable iff (rst_i)
    (ier_reg[3:0] == 4'h0 && ier_reg[7:5] == 3'h0) [*2] |-> !irq_o)
    else $error("irq while interrupt system disabled");

  // Queued error wins the ident read
  chk_line_top: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    rd_ident && rx_err_any_i && ier_reg[IE_LINE] |=> wb_ack_o && wb_dat_o[5:0] == IID_LINE)
    else $error("line status not reported first");

  // Receive data ranks above transmit empty
  chk_rx_prio: assert property ( // R7
    @(posedge clk_i) disable iff (rst_i)
    rd_ident && pend[PR_RXD] && !pend[PR_LINE] && !pend[PR_TOUT]
    |=> wb_dat_o[5:0] == IID_RXD)
    else $error("receive data code wrong");

  // Idle ident shows nothing pending
  chk_ident_none: assert property ( // R4
    @(posedge clk_i) disable iff (rst_i)
    rd_ident && !(|pend) |=> wb_dat_o[0] && wb_dat_o[5:1] == 5'h00)
    else $error("ident not idle with nothing pending");

  // Time-out cleared by a holding read
  chk_tout_clear: assert property ( // R6
    @(posedge clk_i) disable iff (rst_i)
    rd_data && !rx_stale_i |=> !sb.q[SB_TOUT] ##1 rx_read_o == 1'b0)
    else $error("time-out not cleared by holding read");

  // Holding write ends the transmit interrupt
  chk_thr_clear: assert property ( // R8
    @(posedge clk_i) disable iff (rst_i)
    wr_data && !sb.set[SB_THR] |=> !sb.q[SB_THR] && tx_write_o)
    else $error("transmit interrupt not cleared by write");

  // Overrun cleared by a status read
  chk_ovr_clear: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    rd_lstat && !overrun_i |=> !sb.q[SB_OVR])
    else $error("overrun not cleared by status read");

  // Flow-stop from stop character ends on resume character
  chk_xoff_flow: assert property ( // R10
    @(posedge clk_i) disable iff (rst_i)
    sb.q[SB_XOFF] && !xspec_reg && xon_det_i && !sb.set[SB_XOFF] |=> !sb.q[SB_XOFF])
    else $error("flow-stop not cleared by resume");

  // Flow-stop from special character ends on status read
  chk_xoff_spec: assert property ( // R11
    @(posedge clk_i) disable iff (rst_i)
    sb.q[SB_XOFF] && xspec_reg && rd_lstat && !sb.set[SB_XOFF] |=> !sb.q[SB_XOFF])
    else $error("special flow-stop not cleared by status read");

  // CTS going inactive raises its flag next cycle
  chk_cts_rise: assert property ( // R12
    @(posedge clk_i) disable iff (rst_i)
    cts_n_i && !cts_prev_reg |=> sb.q[SB_CTS])
    else $error("cts change not flagged");

  // Error summary alone drives level 1 while enabled
  chk_err_level: assert property ( // R9
    @(posedge clk_i) disable iff (rst_i)
    (rx_err_any_i && ier_reg[IE_LINE]) [*2] |-> irq_o)
    else $error("error summary not driving interrupt");

endmodule

// File: verif/uart_interrupt_prioritizer_bench.sv
// Self-checking bench for the interrupt prioritizer with random traffic
`timescale 1ns/100ps
module uart_interrupt_prioritizer_bench;
  import uip_pkg::*;
  localparam logic [5:0] E_OVR = 6'h01, E_TOUT = 6'h02, E_XOFF = 6'h04;
  localparam logic [5:0] E_XON = 6'h08, E_SPEC = 6'h10, E_PUSH = 6'h20;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, irq, rx_read, tx_write, avail, err_any, tx_empty;
  logic [2:0]  err_top;
  logic [7:0]  rx_data, tx_data, d, d2, m;
  logic        trig = 1'h0, fifo_en = 1'h0, bad = 1'h0;
  logic        ovr = 1'h0, stale = 1'h0, xoff = 1'h0, xon = 1'h0, spec = 1'h0, push = 1'h0;
  logic [7:0]  pdat = 8'h00;
  logic [1:0]  modem_n = 2'h3;
  int          errors = 0;
  int          n_checks = 0;
  int          seed = 17;

  // Free-running bus clock
  always #12.5 clk_i = ~clk_i;

  uip_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_data_i(rx_data), .rx_avail_i(avail), .rx_trig_i(trig), .fifo_en_i(fifo_en),
    .rx_err_any_i(err_any), .rx_err_top_i(err_top), .overrun_i(ovr), .rx_stale_i(stale),
    .tx_empty_i(tx_empty), .xoff_det_i(xoff), .xon_det_i(xon), .special_det_i(spec),
    .rts_n_i(modem_n[0]), .cts_n_i(modem_n[1]), .irq_o(irq), .rx_read_o(rx_read),
    .tx_write_o(tx_write), .tx_data_o(tx_data)
  );

  uip_core_model core (
    .clk_i(clk_i), .rst_i(rst_i), .push_i(push), .push_bad_i(bad), .push_data_i(pdat),
    .rx_read_i(rx_read), .tx_write_i(tx_write), .rx_avail_o(avail),
    .rx_err_any_o(err_any), .rx_err_top_o(err_top), .rx_data_o(rx_data),
    .tx_empty_o(tx_empty)
  );

  task results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected line status word built from the package bit positions
  function automatic logic [31:0] lstat_exp(input logic av, input logic ov,
                                            input logic [2:0] top, input logic te,
                                            input logic es);
    logic [31:0] v;
    v = 32'h0;
    v[LS_DAVAIL] = av;
    v[LS_OVR] = ov;
    v[LS_ERRTOP +: 3] = top;
    v[LS_THRE] = te;
    v[LS_ERRSUM] = es;
    return v;
  endfunction

  // One classic cycle; the wait is bounded so a silent slave ends the run
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] v,
                    output logic [31:0] r);
    int k;
    k = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, v};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'h1 && k < 20);
    // Nothing may follow the closing report, so the release sits in the else
    if (ack !== 1'h1) begin
      errors++;
      results();
    end else begin
      r = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      @(posedge clk_i);
    end
  endtask

  task id(input logic [5:0] e);
    wb(1'h0, OFS_IDENT, 8'h00, q);
    chk(q, {26'h0, e});
  endtask

  task irqc(input logic e);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // One-cycle event pulses, then time for flag and pin to follow
  task ev(input logic [5:0] k);
    {push, spec, xon, xoff, stale, ovr} <= k;
    @(posedge clk_i);
    {push, spec, xon, xoff, stale, ovr} <= 6'h00;
    repeat (3) @(posedge clk_i);
  endtask

  task fin(input string s);
    $display("test %s done", s);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    irqc(1'h0);
    id(IID_NONE);
    wb(1'h0, OFS_ENABLE, 8'h00, q);
    chk(q, 32'h0);
    wb(1'h0, OFS_LSTAT, 8'h00, q);
    chk(q, lstat_exp(1'h0, 1'h0, 3'h0, 1'h1, 1'h0));
    fin("reset");
    // Empty holding register from reset shows once enabled; the ident read takes it
    wb(1'h1, OFS_ENABLE, 8'hFF, q);
    repeat (2) @(posedge clk_i);
    irqc(1'h1);
    id(IID_THR);
    repeat (2) @(posedge clk_i);
    irqc(1'h0);
    id(IID_NONE);
    fin("ident clear");
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      pdat <= d;
      ev(E_PUSH);
      irqc(1'h1);
      id(IID_RXD);
      wb(1'h0, OFS_DATA, 8'h00, q);
      chk(q, {24'h0, d});
      repeat (2) @(posedge clk_i);
      id(IID_NONE);
    end
    fin("receive");
    // Bad character ahead of a good one: errors outrank data until read out
    d = 8'($random(seed));
    d2 = 8'($random(seed));
    pdat <= d;
    bad <= 1'h1;
    ev(E_PUSH);
    pdat <= d2;
    bad <= 1'h0;
    ev(E_PUSH);
    id(IID_LINE);
    wb(1'h0, OFS_LSTAT, 8'h00, q);
    chk(q, lstat_exp(1'h1, 1'h0, 3'h2, 1'h1, 1'h1));
    wb(1'h0, OFS_DATA, 8'h00, q);
    chk(q, {24'h0, d});
    repeat (2) @(posedge clk_i);
    id(IID_RXD);
    wb(1'h0, OFS_DATA, 8'h00, q);
    repeat (2) @(posedge clk_i);
    id(IID_NONE);
    ev(E_OVR);
    id(IID_LINE);
    wb(1'h0, OFS_LSTAT, 8'h00, q);
    chk(q, lstat_exp(1'h0, 1'h1, 3'h0, 1'h1, 1'h0));
    repeat (2) @(posedge clk_i);
    id(IID_NONE);
    fin("line status");
    ev(E_TOUT | E_XOFF);
    id(IID_TOUT);
    wb(1'h0, OFS_DATA, 8'h00, q);
    repeat (2) @(posedge clk_i);
    id(IID_XOFF);
    ev(E_XON);
    id(IID_NONE);
    ev(E_SPEC);
    id(IID_XOFF);
    id(IID_XOFF);
    wb(1'h0, OFS_LSTAT, 8'h00, q);
    repeat (2) @(posedge clk_i);
    id(IID_NONE);
    fin("flow stop");
    for (int i = 0; i < 2; i++) begin
      // Whole-vector drive keeps the loop index off a scheduled assignment target
      modem_n <= (i == 0) ? 2'h2 : 2'h1;
      repeat (3) @(posedge clk_i);
      irqc(1'h0);
      modem_n <= 2'h3;
      repeat (3) @(posedge clk_i);
      id(IID_FLOW);
      id(IID_NONE);
    end
    fin("modem lines");
    // First mask keeps only the sleep bit, which must silence the pin
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 8'h10 : 8'($random(seed));
      wb(1'h1, OFS_ENABLE, m, q);
      wb(1'h0, OFS_ENABLE, 8'h00, q);
      chk(q, {24'h0, m});
      ev(E_XOFF);
      irqc(m[IE_XOFF]);
      id(m[IE_XOFF] ? IID_XOFF : IID_NONE);
      ev(E_XON);
      irqc(1'h0);
    end
    fin("enables");
    // Queues on: data waits for the trigger level, a drained holding stays quiet
    wb(1'h1, OFS_ENABLE, 8'hFF, q);
    fifo_en <= 1'h1;
    ev(E_PUSH);
    id(IID_NONE);
    trig <= 1'h1;
    repeat (2) @(posedge clk_i);
    id(IID_RXD);
    trig <= 1'h0;
    wb(1'h0, OFS_DATA, 8'h00, q);
    d = 8'($random(seed));
    wb(1'h1, OFS_DATA, d, q);
    chk({24'h0, tx_data}, {24'h0, d});
    repeat (16) @(posedge clk_i);
    id(IID_NONE);
    fifo_en <= 1'h0;
    wb(1'h1, OFS_DATA, d, q);
    repeat (16) @(posedge clk_i);
    irqc(1'h1);
    wb(1'h1, OFS_DATA, d, q);
    repeat (2) @(posedge clk_i);
    id(IID_NONE);
    fin("transmit");
    results();
  end
endmodule

// File: verif/uip_core_model.sv
// Behavioural stand-in for the receive queue and transmit holding register
`timescale 1ns/100ps
module uip_core_model (
  input  wire logic       clk_i,        // System clock
  input  wire logic       rst_i,        // Synchronous reset
  input  wire logic       push_i,       // Load one received character
  input  wire logic       push_bad_i,   // Loaded character has a framing error
  input  wire logic [7:0] push_data_i,  // Loaded character
  input  wire logic       rx_read_i,    // Holding register read pulse
  input  wire logic       tx_write_i,   // Holding register write pulse
  output logic            rx_avail_o,   // Data available
  output logic            rx_err_any_o, // Error anywhere in queue
  output logic      [2:0] rx_err_top_o, // Head character errors
  output logic      [7:0] rx_data_o,    // Head character
  output logic            tx_empty_o    // Transmit holding empty
);
  logic [8:0] q[$];
  logic [7:0] last;
  int         n_bad;
  int         tx_busy;
  // Queue and shifter; the shifter drains slowly so the holding register stays full a while
  always @(posedge clk_i) begin
    if (rst_i) begin
      q.delete();
      n_bad = 0;
      tx_busy = 0;
      last = 8'h00;
    end else begin
      if (rx_read_i && q.size() > 0) begin
        last = q[0][7:0];
        n_bad -= int'(q[0][8]);
        void'(q.pop_front());
      end
      if (push_i) begin
        q.push_back({push_bad_i, push_data_i});
        n_bad += int'(push_bad_i);
      end
      if (tx_write_i) tx_busy = 12;
      else if (tx_busy > 0) tx_busy--;
    end
    rx_avail_o   <= q.size() > 0;
    rx_err_any_o <= n_bad > 0;
    rx_err_top_o <= (q.size() > 0 && q[0][8]) ? 3'h2 : 3'h0;
    // An empty queue shows no stale character, so a wrong capture stands out
    rx_data_o    <= (q.size() > 0) ? q[0][7:0] : ~last;
    tx_empty_o   <= tx_busy == 0;
  end
endmodule
